//--- design/sps_pkg.sv
package sps_pkg;
    // ************************************************************
    // Register map (word addresses on the bus, byte offset / 4)
    // ************************************************************
    localparam logic [3:0] SPS_ADR_STATUS  = 4'h0;
    localparam logic [3:0] SPS_ADR_CONTROL = 4'h1;
    localparam logic [3:0] SPS_ADR_BUFFER  = 4'h2;
    localparam logic [3:0] SPS_ADR_IRQ_ST  = 4'h3;
    localparam logic [3:0] SPS_ADR_IRQ_MSK = 4'h4;
    // ************************************************************
    // Status field positions
    // ************************************************************
    localparam int SPS_ST_SMP = 7;
    localparam int SPS_ST_CKE = 6;
    localparam int SPS_ST_DA  = 5;
    localparam int SPS_ST_P   = 4;
    localparam int SPS_ST_S   = 3;
    localparam int SPS_ST_RW  = 2;
    localparam int SPS_ST_UA  = 1;
    localparam int SPS_ST_BF  = 0;
    // Control field positions
    localparam int SPS_CT_EN  = 0;
    localparam int SPS_CT_I2C = 1;
    // Interrupt event positions
    localparam int SPS_EV_START = 0;
    localparam int SPS_EV_STOP  = 1;
    localparam int SPS_EV_RX    = 2;
    localparam int SPS_EV_TXD   = 3;
    localparam int SPS_EV_N     = 4;
    // Reset values
    localparam logic [7:0] SPS_RST_BYTE = 8'h00;
    localparam logic [1:0] SPS_RST_CTRL = 2'h0;
endpackage : sps_pkg

//--- design/sps_flag.sv
`timescale 1ns/10ps
// Sticky flag: set wins over clear
module sps_flag (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Control
    input  wire logic set_i,
    input  wire logic clr_i,
    // State
    output logic      flag_o
);
    // Set has priority so no event is lost
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_o <= 1'b0;
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (clr_i) begin
            flag_o <= 1'b0;
        end
    end
endmodule : sps_flag

//--- design/sps_status.sv
`timescale 1ns/10ps
module sps_status (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [5:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // Bus engine events (same clock)
    input  wire logic        start_det_i,
    input  wire logic        stop_det_i,
    input  wire logic        byte_done_i,
    input  wire logic        byte_is_data_i,
    input  wire logic        rx_byte_i,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        tx_busy_i,
    input  wire logic        rw_i,
    input  wire logic        ua_i,
    // To bus engine
    output logic [7:0]       tx_data_o,
    output logic             tx_start_o,
    output logic             module_enable_bit_o,
    output logic             i2c_mode_o,
    output logic             smp_o,
    output logic             cke_o,
    // Interrupt
    output logic             irq_o
);
    import sps_pkg::*;

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic        req;
    logic        wr;
    logic        rd;
    logic [3:0]  word;
    logic [7:0]  status_reg;
    logic [1:0]  ctrl_reg;
    logic [1:0]  cfg_reg;
    logic [7:0]  rxbuf_reg;
    logic [SPS_EV_N-1:0] ev_st;
    logic [SPS_EV_N-1:0] mask_reg;
    logic [SPS_EV_N-1:0] ev_set;
    logic        tx_busy_d_reg;
    logic        en;
    logic        i2c;

    assign word = adr_i[5:2];
    assign req  = cyc_i & stb_i & ~ack_o;
    assign wr   = req & we_i & sel_i[0];
    assign rd   = req & ~we_i;
    assign en   = ctrl_reg[SPS_CT_EN];
    assign i2c  = en & ctrl_reg[SPS_CT_I2C];

    // Ack one cycle after request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    // Read data mux, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (rd) begin
            unique case (word)
                SPS_ADR_STATUS:  dat_o <= {24'h000000, status_reg};
                SPS_ADR_CONTROL: dat_o <= {30'h0, ctrl_reg};
                SPS_ADR_BUFFER:  dat_o <= {24'h000000, rxbuf_reg};
                SPS_ADR_IRQ_ST:  dat_o <= {28'h0, ev_st};
                SPS_ADR_IRQ_MSK: dat_o <= {28'h0, mask_reg};
                default:         dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // Control, configuration and mask registers
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= SPS_RST_CTRL;
            mask_reg <= '0;
            cfg_reg  <= 2'h0;
        end else if (wr && word == SPS_ADR_CONTROL) begin
            ctrl_reg <= dat_i[1:0];
        end else if (wr && word == SPS_ADR_IRQ_MSK) begin
            mask_reg <= dat_i[SPS_EV_N-1:0];
        end else if (wr && word == SPS_ADR_STATUS) begin
            cfg_reg  <= dat_i[SPS_ST_SMP:SPS_ST_CKE];
        end
    end
    assign module_enable_bit_o = en;
    assign i2c_mode_o          = ctrl_reg[SPS_CT_I2C];
    assign smp_o               = cfg_reg[1];
    assign cke_o               = cfg_reg[0];

    // Transmit launch on buffer write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_data_o  <= SPS_RST_BYTE;
            tx_start_o <= 1'b0;
        end else begin
            tx_start_o <= wr && word == SPS_ADR_BUFFER && en;
            if (wr && word == SPS_ADR_BUFFER) begin
                tx_data_o <= dat_i[7:0];
            end
        end
    end

    // Received byte capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxbuf_reg <= SPS_RST_BYTE;
        end else if (rx_byte_i) begin
            rxbuf_reg <= rx_data_i;
        end
    end

    // ************************************************************
    // Bus condition and byte type flags
    // ************************************************************
    logic da_reg;
    logic p_reg;
    logic s_reg;
    logic bf_reg;
    logic rw_reg;
    logic ua_reg;

    // Data or address of last byte
    always_ff @(posedge clk_i) begin
        if (rst_i || !en) begin
            da_reg <= 1'b0;
        end else if (i2c && byte_done_i) begin
            da_reg <= byte_is_data_i;
        end
    end

    // Last condition: start and stop exclude each other
    always_ff @(posedge clk_i) begin
        if (rst_i || !en) begin
            s_reg <= 1'b0;
            p_reg <= 1'b0;
        end else if (i2c && start_det_i) begin
            s_reg <= 1'b1;
            p_reg <= 1'b0;
        end else if (i2c && stop_det_i) begin
            s_reg <= 1'b0;
            p_reg <= 1'b1;
        end
    end

    // Direction and address update snapshots
    always_ff @(posedge clk_i) begin
        if (rst_i || !en) begin
            rw_reg <= 1'b0;
            ua_reg <= 1'b0;
        end else begin
            rw_reg <= i2c ? rw_i : 1'b0;
            ua_reg <= i2c ? ua_i : 1'b0;
        end
    end

    // Buffer full: set beats clear
    always_ff @(posedge clk_i) begin
        if (rst_i || !en) begin
            bf_reg <= 1'b0;
        end else if (rx_byte_i || tx_start_o || tx_busy_i) begin
            bf_reg <= 1'b1;
        end else if ((rd && word == SPS_ADR_BUFFER)
                     || (tx_busy_d_reg && !tx_busy_i)) begin
            bf_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_busy_d_reg <= 1'b0;
        end else begin
            tx_busy_d_reg <= tx_busy_i;
        end
    end

    // Status byte assembly
    always_comb begin
        status_reg              = SPS_RST_BYTE;
        status_reg[SPS_ST_SMP]  = cfg_reg[1];
        status_reg[SPS_ST_CKE]  = cfg_reg[0];
        status_reg[SPS_ST_DA]   = da_reg;
        status_reg[SPS_ST_P]    = p_reg;
        status_reg[SPS_ST_S]    = s_reg;
        status_reg[SPS_ST_RW]   = rw_reg;
        status_reg[SPS_ST_UA]   = ua_reg;
        status_reg[SPS_ST_BF]   = bf_reg;
    end

    // ************************************************************
    // Interrupt status, cleared by read
    // ************************************************************
    always_comb begin
        ev_set               = '0;
        ev_set[SPS_EV_START] = i2c & start_det_i;
        ev_set[SPS_EV_STOP]  = i2c & stop_det_i;
        ev_set[SPS_EV_RX]    = en & rx_byte_i;
        ev_set[SPS_EV_TXD]   = tx_busy_d_reg & ~tx_busy_i;
    end

    genvar gi;
    generate
        for (gi = 0; gi < SPS_EV_N; gi++) begin : g_ev
            sps_flag u_flag (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .set_i  (ev_set[gi]),
                .clr_i  (rd && word == SPS_ADR_IRQ_ST),
                .flag_o (ev_st[gi])
            );
        end
    endgenerate

    assign irq_o = |(ev_st & mask_reg);
endmodule : sps_status

//--- tb/sps_status_monitor.sv
`timescale 1ns/10ps
// ****
// Status checker
// ****
module sps_status_monitor
    import sps_pkg::*;
(
    // Clock, reset and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        we_i,
    input wire logic [5:0]  adr_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // Engine side
    input wire logic        start_det_i,
    input wire logic        stop_det_i,
    input wire logic        byte_done_i,
    input wire logic        byte_is_data_i,
    input wire logic        tx_busy_i,
    input wire logic        module_enable_bit_o,
    input wire logic        i2c_mode_o
);
    logic s_reg, p_reg, d_reg, seen_reg, rd;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Status read answered now
    assign rd = ack_o && !we_i && adr_i[5:2] == SPS_ADR_STATUS;
    // Expected condition flags
    always_ff @(posedge clk_i) begin
        if (rst_i || !module_enable_bit_o) begin
            {s_reg, p_reg, d_reg} <= 3'h0;
        end else if (i2c_mode_o) begin
            if (start_det_i) {s_reg, p_reg} <= 2'h2;
            else if (stop_det_i) {s_reg, p_reg} <= 2'h1;
            if (byte_done_i) d_reg <= byte_is_data_i;
        end
    end
    // Any start since reset
    always_ff @(posedge clk_i) begin
        if (rst_i) seen_reg <= 1'b0;
        else if (start_det_i) seen_reg <= 1'b1;
    end
    a_data_flag: assert property (
        rd |-> dat_o[SPS_ST_DA] == $past(d_reg)) else $error("data flag");
    a_stop_flag: assert property (
        rd |-> dat_o[SPS_ST_P] == $past(p_reg)) else $error("stop flag");
    a_start_flag: assert property (
        rd |-> dat_o[SPS_ST_S] == $past(s_reg)) else $error("start flag");
    a_start_off: assert property (
        rd && !$past(module_enable_bit_o, 2) |-> !dat_o[SPS_ST_S])
        else $error("start flag while disabled");
    a_start_reset: assert property (
        rd && !$past(seen_reg) |-> !dat_o[SPS_ST_S])
        else $error("start flag before any start");
    a_full_busy: assert property (
        rd && $past(tx_busy_i, 2) && $past(tx_busy_i) |-> dat_o[SPS_ST_BF])
        else $error("full flag low while busy");
    c_start: cover property (rd && dat_o[SPS_ST_S]);
    c_stop: cover property (rd && dat_o[SPS_ST_P]);
    c_full: cover property (rd && dat_o[SPS_ST_BF]);
endmodule : sps_status_monitor

//--- tb/sps_engine_model.sv
`timescale 1ns/10ps
module sps_engine_model (
    // Clock, reset, command
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [2:0] op_i,
    input  wire logic       tx_start_i,
    // Events to the block
    output logic            start_o,
    output logic            stop_o,
    output logic            done_o,
    output logic            data_o,
    output logic            rx_o,
    output logic [7:0]      rx_data_o,
    output logic            busy_o
);
    logic [2:0] cnt_reg;
    // Decode op: 1 start, 2 stop, 3 data, 4 address, 5 receive
    assign start_o = op_i == 3'h1;
    assign stop_o = op_i == 3'h2;
    assign done_o = op_i == 3'h3 || op_i == 3'h4;
    assign data_o = op_i[0]; // Toggles when not qualified
    assign rx_o = op_i == 3'h5;
    assign rx_data_o = rx_o ? 8'hA5 : 8'h5A;
    assign busy_o = cnt_reg != 3'h0;
    // Busy window after each transmit start
    always_ff @(posedge clk_i) begin
        if (rst_i) cnt_reg <= 3'h0;
        else if (tx_start_i) cnt_reg <= 3'h5;
        else if (busy_o) cnt_reg <= cnt_reg - 3'h1;
    end
endmodule : sps_engine_model

//--- tb/sps_status_bench.sv
`timescale 1ns/10ps
module sps_status_bench;
    import sps_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic [31:0] dat = 32'h0;
    logic [2:0]  op = 3'h0;
    logic [31:0] q, dat_o;
    logic [7:0]  rxd, txd;
    logic        ack, txs, en, i2c, irq, st, sp, dn, isd, rx, busy;
    logic        smp, cke;
    int          err_count = 0;
    int          check_count = 0;
    always #10 clk_i = ~clk_i;
    sps_status dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat),
        .dat_o(dat_o), .ack_o(ack), .start_det_i(st), .stop_det_i(sp),
        .byte_done_i(dn), .byte_is_data_i(isd), .rx_byte_i(rx),
        .rx_data_i(rxd), .tx_busy_i(busy), .rw_i(1'b0), .ua_i(1'b0),
        .tx_data_o(txd), .tx_start_o(txs), .module_enable_bit_o(en),
        .i2c_mode_o(i2c), .smp_o(smp), .cke_o(cke), .irq_o(irq));
    sps_engine_model eng_u (.clk_i(clk_i), .rst_i(rst_i), .op_i(op),
        .tx_start_i(txs), .start_o(st), .stop_o(sp), .done_o(dn),
        .data_o(isd), .rx_o(rx), .rx_data_o(rxd), .busy_o(busy));
    task automatic print_verdict();
        if (err_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One classic cycle, held until ack
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        {cyc, stb, we} <= {2'h3, w};
        adr <= {a, 2'h0};
        dat <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            err_count++;
            $display("MISMATCH %0t bus timeout", $time);
            print_verdict();
        end
        q = dat_o;
        {cyc, stb} <= 2'h0;
    endtask : wb
    task automatic ev(input logic [2:0] c);
        @(posedge clk_i) op <= c;
        @(posedge clk_i) op <= 3'h0;
        @(posedge clk_i);
    endtask : ev
    task automatic t_reset();
        wb(0, SPS_ADR_STATUS, 0); chk(q[7:0], 8'h00);
        wb(0, SPS_ADR_CONTROL, 0); chk(q[7:0], 8'h00);
        wb(0, 4'hF, 0); chk(q[7:0], 8'h00);
        ev(1); wb(0, SPS_ADR_STATUS, 0); chk(q[7:0], 8'h00);
    endtask : t_reset
    task automatic t_bus();
        wb(1, SPS_ADR_CONTROL, 8'h03);
        ev(1); wb(0, SPS_ADR_STATUS, 0); chk(q[7:0], 8'h08);
        ev(4); wb(0, SPS_ADR_STATUS, 0); chk(q[7:0], 8'h08);
        ev(3); wb(0, SPS_ADR_STATUS, 0); chk(q[7:0], 8'h28);
        ev(2); wb(0, SPS_ADR_STATUS, 0); chk(q[7:0], 8'h30);
        ev(1); wb(0, SPS_ADR_STATUS, 0); chk(q[7:0], 8'h28);
        wb(1, SPS_ADR_CONTROL, 8'h02);
        wb(0, SPS_ADR_STATUS, 0); chk(q[7:0], 8'h00);
        wb(1, SPS_ADR_CONTROL, 8'h03);
        wb(0, SPS_ADR_STATUS, 0); chk(q[7:0], 8'h00);
    endtask : t_bus
    task automatic t_buffer();
        wb(0, SPS_ADR_IRQ_ST, 0);
        wb(1, SPS_ADR_IRQ_MSK, 8'h04);
        ev(5); chk({7'h0, irq}, 8'h01);
        wb(0, SPS_ADR_STATUS, 0); chk(q[7:0], 8'h01);
        wb(0, SPS_ADR_BUFFER, 0); chk(q[7:0], 8'hA5);
        wb(0, SPS_ADR_STATUS, 0); chk(q[7:0], 8'h00);
        wb(0, SPS_ADR_IRQ_ST, 0); chk(q[7:0], 8'h04);
        chk({7'h0, irq}, 8'h00);
        wb(1, SPS_ADR_IRQ_MSK, 8'h00);
        ev(5); chk({7'h0, irq}, 8'h00);
        wb(0, SPS_ADR_BUFFER, 0);
        wb(1, SPS_ADR_BUFFER, 8'h3C);
        chk(txd, 8'h3C);
        wb(0, SPS_ADR_STATUS, 0); chk(q[7:0], 8'h01);
        wb(0, SPS_ADR_STATUS, 0); chk(q[7:0], 8'h01);
        repeat (10) @(posedge clk_i);
        wb(0, SPS_ADR_STATUS, 0); chk(q[7:0], 8'h00);
        wb(0, SPS_ADR_IRQ_ST, 0); chk(q[7:0], 8'h0C);
    endtask : t_buffer
    // Configuration bits and control readback
    task automatic t_cfg();
        wb(1, SPS_ADR_STATUS, 8'hC0);
        wb(0, SPS_ADR_STATUS, 0); chk(q[7:0], 8'hC0);
        chk({6'h0, smp, cke}, 8'h03);
        wb(0, SPS_ADR_CONTROL, 0); chk(q[7:0], 8'h03);
        chk({6'h0, en, i2c}, 8'h03);
    endtask : t_cfg
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_bus();
        t_buffer();
        t_cfg();
        print_verdict();
    end
endmodule : sps_status_bench
bind sps_status sps_status_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i),
    .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
    .start_det_i(start_det_i), .stop_det_i(stop_det_i),
    .byte_done_i(byte_done_i), .byte_is_data_i(byte_is_data_i),
    .tx_busy_i(tx_busy_i), .module_enable_bit_o(module_enable_bit_o),
    .i2c_mode_o(i2c_mode_o));
